// file: include/uart_pkg.sv
/*
  Shared constants and types for the asynchronous serial transceiver:
  register addresses, reset values, field layouts, parity codes, states.
  Assumes a CPU byte port on a 16-bit address space.
*/
`default_nettype none
package uart_pkg;
  // register addresses on the byte port
  localparam logic [15:0] MODE_ADDR = 16'hff70;
  localparam logic [15:0] BAUD_ADDR = 16'hff71;
  localparam logic [15:0] DATA_ADDR = 16'hff72;
  localparam logic [15:0] STAT_ADDR = 16'hff73;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] BAUD_RESET = 8'h1f;
  localparam logic [7:0] RXB_RESET  = 8'hff;
  localparam logic [7:0] TXS_RESET  = 8'hff;
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] READ_NONE  = 8'h00;
  // data masks and last bit index per character length
  localparam logic [7:0] MASK8 = 8'hff;
  localparam logic [7:0] MASK7 = 8'h7f;
  localparam logic [2:0] LAST8 = 3'h7;
  localparam logic [2:0] LAST7 = 3'h6;
  // parity select codes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // base clock select codes and prescale masks
  localparam logic [1:0] BASE_TIMER = 2'h0;
  localparam logic [1:0] BASE_DIV2  = 2'h1;
  localparam logic [1:0] BASE_DIV8  = 2'h2;
  localparam logic [4:0] PRE_MASK2  = 5'h01;
  localparam logic [4:0] PRE_MASK8  = 5'h07;
  localparam logic [4:0] PRE_MASK32 = 5'h1f;
  localparam logic [4:0] K_STEP     = 5'h01;

  typedef struct packed {
    logic       power;
    logic       tx_en;
    logic       rx_en;
    logic [1:0] parity;
    logic       char8;
    logic       stop2;
    logic       one;
  } mode_t;

  typedef struct packed {
    logic [1:0] base_sel;
    logic       zero;
    logic [4:0] k;
  } baud_t;

  typedef struct packed {
    logic [4:0] zero;
    logic       parity_err;
    logic       framing_err;
    logic       overrun_err;
  } status_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_DATA, TX_PAR, TX_STOP
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
  } rx_state_t;
endpackage : uart_pkg
`default_nettype wire

// file: src/uart_core_regs.sv
/*
  Asynchronous serial transceiver with its byte-wide register port:
  mode, baud divider, receive buffer / transmit shift, error status.
  Assumes the CPU port, the timer tick and the serial line partner;
  the serial input is asynchronous and is synchronised here.
*/
// Behaviour
// (R1) each complete received character is copied once into the receive buffer
// (R2) in 7-bit mode the buffer holds bits 0..6, top bit zero
// (R3) on overrun the new character is dropped, buffer unchanged
// (R4) buffer is read-only, all ones after reset or power off
// (R5) writing the transmit register starts sending; reads return nothing
// (R6) transmit register all ones on reset, power off or transmit off
// (R7) software waits one base clock after transmit enable before writing
// (R8) software writes next character only after transmit-complete
// (R9) power bit low resets the unit, stops the clock, forces input high
// (R10) transmit enable low resets the transmitter; high enables it
// (R11) receive enable low resets the receiver; high enables it
// (R12) parity field: none, zero, odd, even for both directions
// (R13) zero parity is never checked on reception
// (R14) character length bit selects 7 or 8 data bits
// (R15) stop length bit sets 1 or 2 sent stop bits; receiver uses one
// (R16) software sets power before enables and clears enables first
// (R17) enabling reception on a low line starts a reception
// (R18) enables follow the base clock; re-enable needs two base clocks
// (R19) software disables directions before changing frame settings
// (R20) mode register resets to 01h; software writes bit 0 as one
// (R21) error status holds three flags, cleared by reset, power or rx off
// (R22) software reads status then buffer to clear an error
// (R23) characters go least significant bit first
// (R24) overrun when buffer unread; framing when first stop bit low
// (R25) bit rate is the divider output over two; divider counts k
// (R26) frame is low start, data, parity, stops; idle line high
`default_nettype none
module uart_core_regs
  import uart_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // cpu byte port
  input  wire logic [15:0] addr,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  // external base clock source, one-cycle pulses
  input  wire logic        timer_tick,
  // serial line
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // event pulses
  output logic             transmit_complete_irq,
  output logic             receive_complete_irq,
  output logic             receive_error_irq
);

  mode_t     mode;
  baud_t     baud;
  status_t   status;
  status_t   next_status;
  logic [7:0] rx_buf;
  logic [7:0] tx_buf;
  logic       rx_full;
  logic       tx_pend;

  ////////////////////////////////////////////////////////////////////
  // address decode and unit reset
  wire sel_mode = addr == MODE_ADDR;
  wire sel_baud = addr == BAUD_ADDR;
  wire sel_data = addr == DATA_ADDR;
  wire sel_stat = addr == STAT_ADDR;
  wire rd_data  = ce & rd & sel_data;
  wire rd_stat  = ce & rd & sel_stat;
  // power off acts as a held reset of all but the mode, baud, input synchroniser and read data regs
  wire urst     = rst | ~mode.power; // R9

  always_ff @(posedge clk) begin
    if (rst) begin
      mode <= MODE_RESET; // R20
      baud <= BAUD_RESET;
    end else if (ce & wr) begin
      if (sel_mode) mode <= wdata;
      if (sel_baud) baud <= {wdata[7:6], 1'h0, wdata[4:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // base clock, k divider, bit phase
  logic [4:0] pre;
  logic [4:0] kcnt;
  logic       bit_phase;
  wire [4:0] pre_mask = (baud.base_sel == BASE_DIV2) ? PRE_MASK2 :
                        (baud.base_sel == BASE_DIV8) ? PRE_MASK8 :
                        PRE_MASK32;
  wire base_tick = (baud.base_sel == BASE_TIMER) ? timer_tick :
                   ((pre & pre_mask) == pre_mask);
  wire half_tick = base_tick & (kcnt == baud.k - K_STEP); // R25
  wire bit_tick  = half_tick & bit_phase; // R25

  always_ff @(posedge clk) begin
    if (urst) begin
      pre       <= 5'h00; // R9
      kcnt      <= 5'h00;
      bit_phase <= 1'h0;
    end else if (ce) begin
      pre <= pre + K_STEP;
      if (half_tick) begin
        kcnt      <= 5'h00;
        bit_phase <= ~bit_phase;
      end else if (base_tick) begin
        kcnt <= kcnt + K_STEP;
      end
    end
  end

  // enables take effect on the base clock only
  logic txe_s;
  logic rxe_s;
  always_ff @(posedge clk) begin
    if (urst) begin
      txe_s <= 1'h0;
      rxe_s <= 1'h0;
    end else if (ce & base_tick) begin
      txe_s <= mode.tx_en; // R18
      rxe_s <= mode.rx_en; // R18
    end
  end

  ////////////////////////////////////////////////////////////////////
  // serial input synchroniser: accept once stages two and three agree
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  logic rx_line;
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_s1   <= 1'h1;
      rx_s2   <= 1'h1;
      rx_s3   <= 1'h1;
      rx_line <= 1'h1;
    end else if (ce) begin
      rx_s1 <= serial_in_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) rx_line <= rx_s3;
    end
  end
  wire rxd = rx_line | ~mode.power; // R9

  ////////////////////////////////////////////////////////////////////
  // transmitter
  tx_state_t  tx_st;
  logic [7:0] tx_sh;
  logic [2:0] tx_cnt;
  logic       tx_scnt;
  logic       tx_pbit;
  wire [7:0] dmask   = mode.char8 ? MASK8 : MASK7; // R14
  wire [2:0] last    = mode.char8 ? LAST8 : LAST7; // R14
  wire       has_par = mode.parity != PAR_NONE; // R12
  wire       tx_xor  = ^(tx_buf & dmask);
  wire       par_out = (mode.parity == PAR_ODD)  ? ~tx_xor :
                       (mode.parity == PAR_EVEN) ? tx_xor : 1'h0; // R12
  wire tx_load = bit_tick & txe_s & tx_pend & (tx_st == TX_IDLE);

  always_ff @(posedge clk) begin
    if (urst | ~mode.tx_en) begin
      tx_buf  <= TXS_RESET; // R6
      tx_pend <= 1'h0;
    end else if (ce) begin
      if (wr & sel_data) begin
        tx_buf  <= wdata; // R5
        tx_pend <= 1'h1;
      end else if (tx_load) begin
        tx_pend <= 1'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (urst | ~txe_s) begin
      tx_st                 <= TX_IDLE; // R10
      serial_out_pin        <= 1'h1; // R26
      tx_sh                 <= 8'h00;
      tx_cnt                <= 3'h0;
      tx_scnt               <= 1'h0;
      tx_pbit               <= 1'h0;
      transmit_complete_irq <= 1'h0;
    end else if (ce) begin
      transmit_complete_irq <= 1'h0;
      if (bit_tick) begin
        unique case (tx_st)
          TX_IDLE: if (tx_pend) begin
            serial_out_pin <= 1'h0; // R26
            tx_sh          <= tx_buf;
            tx_pbit        <= par_out;
            tx_cnt         <= 3'h0;
            tx_st          <= TX_DATA;
          end
          TX_DATA: begin
            serial_out_pin <= tx_sh[0]; // R23
            tx_sh          <= tx_sh >> 1;
            tx_cnt         <= tx_cnt + 3'h1;
            tx_scnt        <= 1'h0;
            if (tx_cnt == last) tx_st <= has_par ? TX_PAR : TX_STOP;
          end
          TX_PAR: begin
            serial_out_pin <= tx_pbit; // R12
            tx_st          <= TX_STOP;
          end
          TX_STOP: begin
            serial_out_pin <= 1'h1;
            if (tx_scnt == mode.stop2) begin // R15
              tx_st                 <= TX_IDLE;
              transmit_complete_irq <= 1'h1;
            end else begin
              tx_scnt <= 1'h1;
            end
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receiver, samples at bit centres counted in half bits
  rx_state_t  rx_st;
  logic [7:0] rx_sh;
  logic [2:0] rx_cnt;
  logic       rx_ph;
  logic       rx_pbit;
  wire rx_mid  = half_tick & rx_ph;
  wire rx_fin  = ce & rx_mid & (rx_st == RX_STOP); // R15
  wire [7:0] rx_data = mode.char8 ? rx_sh : {1'h0, rx_sh[7:1]}; // R2
  wire rx_sum  = ^rx_data ^ rx_pbit;
  wire rx_perr = ((mode.parity == PAR_ODD) & ~rx_sum) |
                 ((mode.parity == PAR_EVEN) & rx_sum); // R13

  always_ff @(posedge clk) begin
    if (urst | ~rxe_s) begin
      rx_st   <= RX_IDLE; // R11
      rx_sh   <= 8'h00;
      rx_cnt  <= 3'h0;
      rx_ph   <= 1'h0;
      rx_pbit <= 1'h0;
    end else if (ce) begin
      unique case (rx_st)
        RX_IDLE: if (~rxd) begin
          rx_st <= RX_START; // R17
          rx_ph <= 1'h0;
        end
        RX_START: if (half_tick) begin
          rx_st  <= rxd ? RX_IDLE : RX_DATA;
          rx_cnt <= 3'h0;
        end
        default: if (half_tick) begin
          rx_ph <= ~rx_ph;
          if (rx_ph) begin
            unique case (rx_st)
              RX_DATA: begin
                rx_sh  <= {rxd, rx_sh[7:1]}; // R23
                rx_cnt <= rx_cnt + 3'h1;
                if (rx_cnt == last)
                  rx_st <= has_par ? RX_PAR : RX_STOP;
              end
              RX_PAR: begin
                rx_pbit <= rxd;
                rx_st   <= RX_STOP;
              end
              default: rx_st <= RX_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // receive buffer and error flags; a new event beats a read clear
  always_comb begin
    next_status             = rd_stat ? STAT_RESET : status;
    next_status.overrun_err = next_status.overrun_err |
                              (rx_fin & rx_full); // R24
    next_status.framing_err = next_status.framing_err |
                              (rx_fin & ~rxd); // R24
    next_status.parity_err  = next_status.parity_err |
                              (rx_fin & rx_perr); // R13
  end

  always_ff @(posedge clk) begin
    if (urst) begin
      rx_buf  <= RXB_RESET; // R4
      rx_full <= 1'h0;
    end else if (ce) begin
      if (rx_fin & ~rx_full) begin
        rx_buf  <= rx_data; // R1
        rx_full <= 1'h1;
      end else if (rd_data) begin
        rx_full <= 1'h0; // R22
      end
    end
  end

  always_ff @(posedge clk) begin
    if (urst | ~mode.rx_en) begin
      status <= STAT_RESET; // R21
    end else if (ce) begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk) begin
    if (urst) begin
      receive_complete_irq <= 1'h0;
      receive_error_irq    <= 1'h0;
    end else if (ce) begin
      receive_complete_irq <= rx_fin;
      receive_error_irq    <= rx_fin & (rx_full | ~rxd | rx_perr);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port, one cycle latency; transmit register not readable, data reads return rx_buf
  wire [7:0] read_mux = sel_mode ? mode :
                        sel_baud ? baud :
                        sel_data ? rx_buf :
                        sel_stat ? status : READ_NONE; // R5
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= READ_NONE;
    end else if (ce & rd) begin
      rdata <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_load;
    tx_load && ce;
  endsequence

  property p_rx7;
    rx_fin && !rx_full && !mode.char8 |=> !rx_buf[7];
  endproperty
  a_rx7: assert property (p_rx7) else $error("7-bit top bit set"); // R2

  property p_ovr;
    rx_fin && rx_full && mode.rx_en && mode.power
      |=> $stable(rx_buf) && status.overrun_err;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun mishandled"); // R3

  property p_rxb_off;
    !mode.power |=> rx_buf == RXB_RESET && status == STAT_RESET;
  endproperty
  a_rxb_off: assert property (p_rxb_off) else $error("power off"); // R9

  property p_tx_off;
    !mode.tx_en |=> tx_buf == TXS_RESET && !tx_pend;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx not cleared"); // R6

  property p_start;
    s_load |=> !serial_out_pin && tx_st == TX_DATA;
  endproperty
  a_start: assert property (p_start) else $error("no start bit"); // R5

  property p_idle;
    tx_st == TX_IDLE |-> serial_out_pin;
  endproperty
  a_idle: assert property (p_idle) else $error("idle line low"); // R26

  property p_zpar;
    rx_fin && mode.parity == PAR_ZERO && !status.parity_err
      |=> !status.parity_err;
  endproperty
  a_zpar: assert property (p_zpar) else $error("zero parity check"); // R13

  property p_rxe_off;
    !mode.rx_en ##1 !mode.rx_en |-> status == STAT_RESET;
  endproperty
  a_rxe_off: assert property (p_rxe_off) else $error("status kept"); // R21

endmodule : uart_core_regs
`default_nettype wire

// file: sim/uart_peer.sv
/*
  Remote serial transceiver that faces the device's serial pins.
  Assumes idle-high lines and the bit time the bench programs.
*/
`default_nettype none
module uart_peer
  import uart_pkg::*;
#(
  parameter int BIT_NS = 320
) (
  // frame settings shared with the device
  input  wire mode_t cfg,
  // serial lines
  input  wire logic  line_in,
  output logic       line_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] got;
  logic       got_par;
  int         frames;
  time        t_start;
  int         i;

  initial begin
    line_out = 1'b1;
    frames = 0;
  end

  //////////////////////////////////////////////////////////////////////////
  // one frame out; stop_ok low forces a bad stop bit
  task automatic send(input logic [7:0] d, input logic p,
                      input logic stop_ok);
    line_out = 1'b0;
    #(BIT_NS);
    for (int b = 0; b < (cfg.char8 ? 8 : 7); b++) begin
      line_out = d[b];
      #(BIT_NS);
    end
    if (cfg.parity != PAR_NONE) begin
      line_out = p;
      #(BIT_NS);
    end
    // single stop bit even when the device sends two
    line_out = stop_ok;
    #(BIT_NS);
    line_out = 1'b1;
    #(BIT_NS);
  endtask : send

  //////////////////////////////////////////////////////////////////////////
  // centre sampling; edges inside a frame are ignored while busy
  always @(negedge line_in) begin
    t_start = $time;
    #(BIT_NS / 2);
    got = 8'h00;
    for (i = 0; i < (cfg.char8 ? 8 : 7); i++) begin
      #(BIT_NS);
      got[i] = line_in;
    end
    if (cfg.parity != PAR_NONE) begin
      #(BIT_NS);
      got_par = line_in;
    end
    #(BIT_NS);
    if (line_in === 1'b1) frames++;
  end
endmodule : uart_peer
`default_nettype wire

// file: sim/uart_core_regs_tb.sv
/*
  Self-checking bench for the serial transceiver and its registers.
  Assumes the peer model on the serial pins and clk/2 as base clock.
*/
`default_nettype none
module uart_core_regs_tb
  import uart_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int K      = 8;
  localparam int BIT_NS = 2 * K * 2 * 10;

  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [15:0] addr = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic        sin;
  logic        sout;
  logic        tx_irq;
  logic        rx_irq;
  logic        err_irq;
  mode_t       m;
  int          tx_cnt = 0;
  int          rx_cnt = 0;
  int          err_cnt = 0;
  int          n;
  time         t_done;
  int          mismatches = 0;
  int          checked = 0;
  logic [7:0]  v;
  logic [7:0]  d;

  always #5 clk = ~clk;

  uart_core_regs u_dut (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata), .rdata(rdata), .timer_tick(1'b0),
    .serial_in_pin(sin), .serial_out_pin(sout),
    .transmit_complete_irq(tx_irq), .receive_complete_irq(rx_irq),
    .receive_error_irq(err_irq)
  );

  uart_peer #(.BIT_NS(BIT_NS)) u_peer (
    .cfg(m), .line_in(sout), .line_out(sin)
  );

  // event pulses are one cycle wide, so count them
  always @(posedge clk) begin
    if (tx_irq === 1'b1) begin
      tx_cnt++;
      t_done = $time;
    end
    if (rx_irq === 1'b1) rx_cnt++;
    if (err_irq === 1'b1) err_cnt++;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic wr8(input logic [15:0] a, input logic [7:0] x);
    @(negedge clk);
    addr = a;
    wdata = x;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr8

  task automatic rd8(input logic [15:0] a, output logic [7:0] x);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    x = rdata;
  endtask : rd8

  task automatic waitc(ref int cnt, input int target);
    for (int i = 0; i < 3 * BIT_NS; i++) begin
      if (cnt >= target) break;
      @(negedge clk);
    end
  endtask : waitc

  // frame fields change only with both directions off
  task automatic setm(input int c);
    m.tx_en = 1'b0;
    m.rx_en = 1'b0;
    wr8(MODE_ADDR, m);
    repeat (8) @(negedge clk);
    m.parity = 2'(c >> 1);
    m.char8 = c[0];
    m.stop2 = c[1] ^ c[0];
    wr8(MODE_ADDR, m);
    m.tx_en = 1'b1;
    m.rx_en = 1'b1;
    wr8(MODE_ADDR, m);
    repeat (8) @(negedge clk);
  endtask : setm

  function automatic logic [7:0] mask(mode_t c, logic [7:0] x);
    return c.char8 ? x : (x & MASK7);
  endfunction : mask

  function automatic logic par(mode_t c, logic [7:0] x);
    if (c.parity == PAR_ODD) return ~^mask(c, x);
    if (c.parity == PAR_EVEN) return ^mask(c, x);
    return 1'b0;
  endfunction : par

  // complete pulse rises as the last stop bit begins, so it is not counted
  function automatic logic [7:0] nbits(mode_t c);
    return 8'(1 + (c.char8 ? 8 : 7) + (c.parity != PAR_NONE) + c.stop2);
  endfunction : nbits

  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hc6b61836));
    m = mode_t'(MODE_RESET);
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd8(MODE_ADDR, v);
    check(v, MODE_RESET);
    rd8(STAT_ADDR, v);
    check(v, STAT_RESET);
    rd8(16'hff7f, v);
    check(v, READ_NONE);
    wr8(DATA_ADDR, 8'h5a);
    rd8(DATA_ADDR, v);
    check(v, RXB_RESET);
    wr8(BAUD_ADDR, {BASE_DIV2, 1'b0, 5'(K)});
    m.power = 1'b1;
    wr8(MODE_ADDR, m);
    repeat (40) @(negedge clk);
    check(8'(u_peer.frames), 8'h00);
    $display("test reset values done");
    for (int c = 0; c < 8; c++) begin
      setm(c);
      // corner bytes at the ends of the loop, random between
      d = (c == 0) ? 8'h00 : (c == 7) ? 8'hff : 8'($urandom);
      n = tx_cnt + 1;
      wr8(DATA_ADDR, d);
      waitc(tx_cnt, n);
      check(8'(tx_cnt - n), 8'h00);
      check(u_peer.got, mask(m, d));
      if (m.parity != PAR_NONE) begin
        check(8'(u_peer.got_par), 8'(par(m, d)));
      end
      t_done = t_done - u_peer.t_start + BIT_NS / 2;
      check(8'(t_done / BIT_NS), nbits(m));
      d = 8'($urandom);
      n = rx_cnt + 1;
      u_peer.send(d, par(m, d), 1'b1);
      waitc(rx_cnt, n);
      check(8'(rx_cnt - n), 8'h00);
      rd8(STAT_ADDR, v);
      check(v, STAT_RESET);
      rd8(DATA_ADDR, v);
      check(v, mask(m, d));
      n = err_cnt;
      u_peer.send(d, ~par(m, d), 1'b1);
      rd8(STAT_ADDR, v);
      check(v, {5'h00, m.parity[1], 2'b00});
      check(8'(err_cnt - n), {7'h00, m.parity[1]});
      rd8(DATA_ADDR, v);
      $display("test frame setting %0d done", c);
    end
    d = 8'($urandom);
    u_peer.send(d, par(m, d), 1'b1);
    u_peer.send(~d, par(m, ~d), 1'b1);
    rd8(STAT_ADDR, v);
    check(v, 8'h01);
    rd8(DATA_ADDR, v);
    check(v, mask(m, d));
    u_peer.send(d, par(m, d), 1'b0);
    rd8(STAT_ADDR, v);
    check(v, 8'h02);
    u_peer.send(d, par(m, d), 1'b0);
    m.rx_en = 1'b0;
    wr8(MODE_ADDR, m);
    repeat (8) @(negedge clk);
    rd8(STAT_ADDR, v);
    check(v, STAT_RESET);
    $display("test receive errors done");
    m.tx_en = 1'b0;
    wr8(MODE_ADDR, m);
    m.power = 1'b0;
    wr8(MODE_ADDR, m);
    rd8(DATA_ADDR, v);
    check(v, RXB_RESET);
    rd8(MODE_ADDR, v);
    check(v, m);
    $display("test power off done");
    results();
  end

  // limit reckoned from the number of frames the tests send
  initial begin
    #(80 * 20 * BIT_NS);
    mismatches++;
    results();
  end
endmodule : uart_core_regs_tb
`default_nettype wire
